// >>> hw/watchdog_timer.sv
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps

// What this block does
// - source is sub clock or system/4
// - sub clock from crystal or internal oscillator
// - select field gives 2^(8+n) periods timeout
// - disabled only by option and key 1010
// - other keys or option enable keep running
// - key field resets to 1010
// - disabled watchdog ignores all its instructions
// - normal overflow: full reset, timeout flag
// - low-power overflow: reset pc and sp
// - cleared by reset pin, clears, halt
// - option picks single or paired clear
// - single clear instruction clears at once
// - paired style needs alternating clear kinds
// - system/4 source stops in stop modes
// - full stop entry clears and halts
// - idle with clock kept clears, keeps counting
module watchdog_timer
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // configuration options
    input wire watchdog_pkg::config_t cfg,
    // low-speed oscillators, sampled as levels
    input wire logic crystal_32k_osc,
    input wire logic internal_32k_osc,
    // core side
    input wire watchdog_pkg::core_ops_t ops,
    input wire watchdog_pkg::power_mode_t power_mode,
    input wire logic external_reset_pin_n,
    // reset requests and flags
    output logic device_reset,
    output logic pc_sp_reset,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic idle_sysclk_keep,
    output logic irq
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] watchdog_control;
    logic [watchdog_pkg::EV_WIDTH-1:0] irq_status;
    logic [watchdog_pkg::EV_WIDTH-1:0] irq_enable;
    logic [watchdog_pkg::COUNT_WIDTH-1:0] count;
    logic [1:0] sys_div;
    logic sub_prev;
    watchdog_pkg::clear_last_t clear_last;
    watchdog_pkg::power_mode_t mode_prev;

    // ------------------------------------------------------------
    // enable decision
    // ------------------------------------------------------------
    wire [3:0] soft_disable_key;
    wire [2:0] timeout_select;
    wire key_disables;
    wire enabled;
    assign soft_disable_key =
        watchdog_control[watchdog_pkg::KEY_HI:watchdog_pkg::KEY_LO];
    assign timeout_select =
        watchdog_control[watchdog_pkg::SEL_HI:watchdog_pkg::SEL_LO];
    assign idle_sysclk_keep = watchdog_control[watchdog_pkg::KEEP_BIT];
    assign key_disables = soft_disable_key == watchdog_pkg::KEY_DISABLE;
    assign enabled = cfg.wdt_enable | ~key_disables;

    // ------------------------------------------------------------
    // source clock ticks
    // ------------------------------------------------------------
    wire sub_level;
    wire sub_tick;
    wire sys_tick;
    wire sys_stopped;
    wire src_tick;
    assign sub_level = cfg.sub_crystal ? crystal_32k_osc : internal_32k_osc;
    assign sub_tick = sub_level & ~sub_prev;
    assign sys_tick = sys_div == 2'(watchdog_pkg::SYS_DIVIDE - 1);
    assign sys_stopped = power_mode == watchdog_pkg::MODE_FULL_STOP
        || power_mode == watchdog_pkg::MODE_IDLE_STOP;
    assign src_tick = power_mode == watchdog_pkg::MODE_FULL_STOP ? 1'b0
        : cfg.src_sub ? sub_tick
        : (sys_tick & ~sys_stopped);

    // ------------------------------------------------------------
    // clear decode: instructions, reset pin and mode entry
    // ------------------------------------------------------------
    wire paired_first;
    wire paired_second;
    wire soft_clear;
    wire mode_entry;
    wire hw_clear;
    assign paired_first = ops.clear_op_first
        & (clear_last != watchdog_pkg::LAST_FIRST);
    assign paired_second = ops.clear_op_second
        & (clear_last != watchdog_pkg::LAST_SECOND);
    assign soft_clear = enabled & (cfg.paired_clear
        ? (paired_first | paired_second) : ops.single_clear_op);
    // entering a low-power mode also clears
    assign mode_entry = power_mode != mode_prev
        && power_mode != watchdog_pkg::MODE_NORMAL;
    assign hw_clear = ~external_reset_pin_n | soft_clear
        | (enabled & ops.halt_op) | mode_entry;

    // ------------------------------------------------------------
    // overflow detection
    // ------------------------------------------------------------
    wire [watchdog_pkg::COUNT_WIDTH-1:0] sel_mask;
    wire overflow;
    wire low_power;
    assign sel_mask = watchdog_pkg::COUNT_WIDTH'(
        (32'h1 << (watchdog_pkg::BASE_SHIFT + 32'(timeout_select))) - 32'h1);
    assign overflow = enabled & src_tick & ~hw_clear
        & ((count & sel_mask) == sel_mask);
    assign low_power = power_mode != watchdog_pkg::MODE_NORMAL;

    // ------------------------------------------------------------
    // counter and clock state
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count <= '0;
            sys_div <= 2'h0;
            // start high so an oscillator already high is no false tick
            sub_prev <= 1'b1;
            mode_prev <= watchdog_pkg::MODE_NORMAL;
        end
        else
        begin
            sys_div <= sys_div + 2'h1;
            sub_prev <= sub_level;
            mode_prev <= power_mode;
            if (hw_clear || overflow || !enabled)
                count <= '0;
            else if (src_tick)
                count <= count + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // paired clear tracking
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !external_reset_pin_n)
            clear_last <= watchdog_pkg::LAST_NONE;
        else if (enabled && cfg.paired_clear && paired_first)
            clear_last <= watchdog_pkg::LAST_FIRST;
        else if (enabled && cfg.paired_clear && paired_second)
            clear_last <= watchdog_pkg::LAST_SECOND;
    end

    // ------------------------------------------------------------
    // reset requests and flags
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            device_reset <= 1'b0;
            pc_sp_reset <= 1'b0;
            timeout_flag <= 1'b0;
            powerdown_flag <= 1'b0;
        end
        else
        begin
            device_reset <= overflow & ~low_power;
            pc_sp_reset <= overflow & low_power;
            // set wins over clear
            if (overflow)
                timeout_flag <= 1'b1;
            else if (soft_clear || (enabled && ops.halt_op))
                timeout_flag <= 1'b0;
            if (enabled && ops.halt_op)
                powerdown_flag <= 1'b1;
            else if (soft_clear)
                powerdown_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    wire wr_take;
    wire wr_control;
    wire wr_irq_clear;
    wire wr_irq_enable;
    wire wr_ok;
    // address and data are taken together so neither waits alone
    assign wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;
    assign wr_control = s_axi_awaddr == watchdog_pkg::ADDR_CONTROL;
    assign wr_irq_clear = s_axi_awaddr == watchdog_pkg::ADDR_IRQ_CLEAR;
    assign wr_irq_enable = s_axi_awaddr == watchdog_pkg::ADDR_IRQ_ENABLE;
    assign wr_ok = wr_control | wr_irq_clear | wr_irq_enable;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= watchdog_pkg::RESP_OKAY;
        end
        else if (wr_take)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? watchdog_pkg::RESP_OKAY
                : watchdog_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            watchdog_control <= watchdog_pkg::CONTROL_RESET;
        else if (wr_take && wr_control && s_axi_wstrb[0])
            watchdog_control <= s_axi_wdata[7:0];
    end

    // ------------------------------------------------------------
    // interrupt status, sticky with set over clear
    // ------------------------------------------------------------
    wire [watchdog_pkg::EV_WIDTH-1:0] events;
    wire [watchdog_pkg::EV_WIDTH-1:0] clear_bits;
    assign clear_bits = (wr_take && wr_irq_clear && s_axi_wstrb[0])
        ? s_axi_wdata[watchdog_pkg::EV_WIDTH-1:0] : '0;

    genvar e;
    generate
        for (e = 0; e < watchdog_pkg::EV_WIDTH; e++)
        begin : g_event
            if (e == watchdog_pkg::EV_OVERFLOW)
            begin : g_ovf
                assign events[e] = overflow;
            end
            else
            begin : g_clr
                assign events[e] = soft_clear;
            end
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    irq_status[e] <= 1'b0;
                else if (events[e])
                    irq_status[e] <= 1'b1;
                else if (clear_bits[e])
                    irq_status[e] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_enable <= '0;
        else if (wr_take && wr_irq_enable && s_axi_wstrb[0])
            irq_enable <= s_axi_wdata[watchdog_pkg::EV_WIDTH-1:0];
    end

    assign irq = |(irq_status & irq_enable);

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    wire rd_take;
    wire [31:0] status_word;
    wire [31:0] rd_word;
    wire rd_ok;
    assign rd_take = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign status_word = {29'h0, enabled, powerdown_flag, timeout_flag};
    // irq_clear is write-only and reads as zero
    assign rd_ok = s_axi_araddr == watchdog_pkg::ADDR_CONTROL
        || s_axi_araddr == watchdog_pkg::ADDR_STATUS
        || s_axi_araddr == watchdog_pkg::ADDR_IRQ_STATUS
        || s_axi_araddr == watchdog_pkg::ADDR_IRQ_CLEAR
        || s_axi_araddr == watchdog_pkg::ADDR_IRQ_ENABLE;
    assign rd_word =
        s_axi_araddr == watchdog_pkg::ADDR_CONTROL
            ? {24'h0, watchdog_control}
        : s_axi_araddr == watchdog_pkg::ADDR_STATUS ? status_word
        : s_axi_araddr == watchdog_pkg::ADDR_IRQ_STATUS
            ? {30'h0, irq_status}
        : s_axi_araddr == watchdog_pkg::ADDR_IRQ_ENABLE
            ? {30'h0, irq_enable}
        : 32'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= watchdog_pkg::RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? watchdog_pkg::RESP_OKAY
                : watchdog_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule

// >>> hw/watchdog_pkg.sv
package watchdog_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;

    // ------------------------------------------------------------
    // watchdog_control fields
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h7A;
    localparam int KEEP_BIT = 7;
    localparam int SEL_HI = 6;
    localparam int SEL_LO = 4;
    localparam int KEY_HI = 3;
    localparam int KEY_LO = 0;
    localparam logic [3:0] KEY_DISABLE = 4'hA;

    // ------------------------------------------------------------
    // status and interrupt bits
    // ------------------------------------------------------------
    localparam int ST_TIMEOUT = 0;
    localparam int ST_POWERDOWN = 1;
    localparam int ST_ENABLED = 2;
    localparam int EV_OVERFLOW = 0;
    localparam int EV_CLEARED = 1;
    localparam int EV_WIDTH = 2;

    // ------------------------------------------------------------
    // counter, clock and bus response constants
    // ------------------------------------------------------------
    localparam int BASE_SHIFT = 8;
    localparam int COUNT_WIDTH = 15;
    localparam int SYS_DIVIDE = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // power mode reported by the core
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_FULL_STOP = 2'b01,
        MODE_IDLE_STOP = 2'b10,
        MODE_IDLE_RUN = 2'b11
    } power_mode_t;

    // last clear instruction seen in paired style
    typedef enum logic [1:0] {
        LAST_NONE = 2'b00,
        LAST_FIRST = 2'b01,
        LAST_SECOND = 2'b10
    } clear_last_t;

    // configuration options, fixed while running
    typedef struct packed {
        logic wdt_enable;
        logic src_sub;
        logic sub_crystal;
        logic paired_clear;
    } config_t;

    // instruction strobes from the core, one cycle each
    typedef struct packed {
        logic single_clear_op;
        logic clear_op_first;
        logic clear_op_second;
        logic halt_op;
    } core_ops_t;

endpackage

// >>> testbench/watchdog_timer_chk.sv
`timescale 1ns/10ps
module watchdog_timer_chk
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // core side
    input wire watchdog_pkg::config_t cfg,
    input wire watchdog_pkg::core_ops_t ops,
    input wire watchdog_pkg::power_mode_t power_mode,
    input wire logic external_reset_pin_n,
    // watchdog outputs
    input wire logic device_reset,
    input wire logic pc_sp_reset,
    input wire logic timeout_flag
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    wr_ready_a: assert property (s_axi_awready ==
        (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
        else $error("write ready mismatch");
    wr_both_ready_a: assert property (s_axi_wready == s_axi_awready)
        else $error("write data ready differs from address ready");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |=>
        s_axi_bvalid) else $error("write response late");
    rd_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read ready mismatch");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read data late");
    rst_pulse_a: assert property (device_reset |=> !device_reset)
        else $error("device reset longer than one cycle");
    ovf_flag_a: assert property (device_reset || pc_sp_reset |->
        timeout_flag && !(device_reset && pc_sp_reset))
        else $error("overflow without timeout flag");
    ovf_mode_a: assert property (device_reset || pc_sp_reset |->
        device_reset == ($past(power_mode) == watchdog_pkg::MODE_NORMAL))
        else $error("overflow reset kind wrong for mode");
    pin_clear_a: assert property (!external_reset_pin_n |->
        ##1 !device_reset && !pc_sp_reset)
        else $error("overflow right after pin clear");
    clear_quiet_a: assert property ((ops.single_clear_op &&
        !cfg.paired_clear) || ops.halt_op |->
        ##1 !device_reset && !pc_sp_reset)
        else $error("overflow right after clear");
    stop_halt_a: assert property ($past(power_mode, 2) ==
        watchdog_pkg::MODE_FULL_STOP && $past(power_mode) ==
        watchdog_pkg::MODE_FULL_STOP |-> !device_reset && !pc_sp_reset)
        else $error("overflow in full stop");
    idle_stop_a: assert property ($past(power_mode, 2) ==
        watchdog_pkg::MODE_IDLE_STOP && $past(power_mode) ==
        watchdog_pkg::MODE_IDLE_STOP && !cfg.src_sub |-> !pc_sp_reset)
        else $error("system clock source counted in idle stop");

    cover property (device_reset);
    cover property (pc_sp_reset);
    cover property (s_axi_bvalid && s_axi_bresp == watchdog_pkg::RESP_SLVERR);
endmodule

// >>> testbench/core_model.sv
`timescale 1ns/10ps
module core_model
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // requests from the bench
    input wire watchdog_pkg::core_ops_t op_req,
    input wire logic sleep_req,
    input wire logic idle_req,
    input wire logic wake_req,
    // from the watchdog
    input wire logic idle_sysclk_keep,
    input wire logic pc_sp_reset,
    // to the watchdog
    output watchdog_pkg::core_ops_t ops,
    output watchdog_pkg::power_mode_t power_mode
);
    // clear kinds passed in bench order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ops <= '0;
            power_mode <= watchdog_pkg::MODE_NORMAL;
        end
        else if (power_mode == watchdog_pkg::MODE_NORMAL &&
                 (sleep_req || idle_req))
        begin
            // halt picks idle kind by keep bit
            ops <= 4'h1;
            power_mode <= sleep_req ? watchdog_pkg::MODE_FULL_STOP :
                idle_sysclk_keep ? watchdog_pkg::MODE_IDLE_RUN :
                watchdog_pkg::MODE_IDLE_STOP;
        end
        else
        begin
            ops <= op_req;
            if (wake_req || pc_sp_reset)
                power_mode <= watchdog_pkg::MODE_NORMAL;
        end
    end
endmodule

// >>> testbench/watchdog_timer_tb_top.sv
`timescale 1ns/10ps
module watchdog_timer_tb_top;
    logic aclk = 1'h0, aresetn = 1'h0, external_reset_pin_n = 1'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, seed = 32'h22;
    logic [3:0] s_axi_wstrb = 4'hF, k;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, device_reset, pc_sp_reset, timeout_flag, irq;
    logic powerdown_flag, idle_sysclk_keep, dr, pr;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic crystal_32k_osc = 1'h0, internal_32k_osc = 1'h0;
    logic sleep_req = 1'h0, idle_req = 1'h0, wake_req = 1'h0;
    logic [2:0] osc_cnt = 3'h0;
    watchdog_pkg::config_t cfg = 4'h0;
    watchdog_pkg::core_ops_t op_req = 4'h0, ops;
    watchdog_pkg::power_mode_t power_mode;
    // sys/4 with three selects, crystal, internal at half rate
    watchdog_pkg::config_t tc [5] = '{4'h8, 4'h8, 4'h8, 4'hE, 4'hC};
    int ts [5] = '{0, 1, 2, 0, 1};
    int tp [5] = '{4, 4, 4, 4, 8};
    int fails = 0, n_tests = 0, n_cyc, e;

    always #5 aclk = ~aclk;
    // slow oscillators: crystal period 4 cycles, internal 8
    always @(posedge aclk)
    begin
        osc_cnt <= osc_cnt + 3'h1;
        crystal_32k_osc <= osc_cnt[1];
        internal_32k_osc <= osc_cnt[2];
    end

    watchdog_timer u_watchdog_timer (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg,
        .crystal_32k_osc, .internal_32k_osc, .ops, .power_mode,
        .external_reset_pin_n, .device_reset, .pc_sp_reset, .timeout_flag,
        .powerdown_flag, .idle_sysclk_keep, .irq);
    core_model u_core_model (.aclk, .aresetn, .op_req, .sleep_req,
        .idle_req, .wake_req, .idle_sysclk_keep, .pc_sp_reset, .ops,
        .power_mode);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do @(posedge aclk); while (!s_axi_awready);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(posedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic op(input watchdog_pkg::core_ops_t r);
        @(posedge aclk);
        op_req <= r;
        @(posedge aclk);
        op_req <= 4'h0;
    endtask

    task automatic req(input logic [2:0] m);
        @(posedge aclk);
        {sleep_req, idle_req, wake_req} <= m;
        @(posedge aclk);
        {sleep_req, idle_req, wake_req} <= 3'h0;
    endtask

    // counts cycles until either reset pulse, or gives up at lim
    task automatic wait_ovf(input int lim);
        n_cyc = 0;
        {dr, pr} = 2'h0;
        while (!(dr | pr) && n_cyc < lim)
        begin
            @(negedge aclk);
            n_cyc++;
            {dr, pr} = {device_reset, pc_sp_reset};
        end
    endtask

    task automatic start(input watchdog_pkg::config_t c, input logic [7:0] w);
        @(posedge aclk);
        aresetn <= 1'h0;
        cfg <= c;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        if (w != watchdog_pkg::CONTROL_RESET)
            axw(watchdog_pkg::ADDR_CONTROL, {24'h0, w});
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // total run is near 30k cycles
    initial
    begin
        #600000;
        fails++;
        tally_and_finish;
    end

    initial
    begin
        start(4'h0, 8'h7A);
        axr(watchdog_pkg::ADDR_CONTROL);
        chk(rd & 32'hFF, 32'h7A);
        axr(watchdog_pkg::ADDR_STATUS);
        chk(rd[watchdog_pkg::ST_ENABLED], 1'h0);
        axr(8'h14);
        chk(resp, watchdog_pkg::RESP_SLVERR);
        axw(8'h14, rnd());
        chk(resp, watchdog_pkg::RESP_SLVERR);
        axr(watchdog_pkg::ADDR_IRQ_ENABLE);
        chk(rd, 32'h0);
        op(4'h1);
        wait_ovf(1500);
        chk({dr, pr, powerdown_flag}, 3'h0);
        for (int i = 0; i < 6; i++)
        begin
            k = (i == 0) ? 4'hA : 4'(rnd());
            axw(watchdog_pkg::ADDR_CONTROL, {28'h0, k});
            chk(resp, watchdog_pkg::RESP_OKAY);
            axr(watchdog_pkg::ADDR_STATUS);
            chk(rd[watchdog_pkg::ST_ENABLED], k != 4'hA);
        end
        start(4'h8, 8'h7A);
        axr(watchdog_pkg::ADDR_STATUS);
        chk(rd[watchdog_pkg::ST_ENABLED], 1'h1);
        for (int i = 0; i < 5; i++)
        begin
            start(tc[i], {1'h0, 3'(ts[i]), 4'h5});
            e = (1 << (8 + ts[i])) * tp[i];
            op(4'h8);
            wait_ovf(2 * e);
            chk(n_cyc > e - tp[i] - 4 && n_cyc < e + tp[i] + 4, 1'h1);
            chk({dr, timeout_flag}, 2'h3);
        end
        axr(watchdog_pkg::ADDR_IRQ_STATUS);
        chk(rd[watchdog_pkg::EV_OVERFLOW], 1'h1);
        chk(rd[watchdog_pkg::EV_CLEARED], 1'h1);
        chk(irq, 1'h0);
        axw(watchdog_pkg::ADDR_IRQ_ENABLE, rnd() | 32'h1);
        chk(irq, 1'h1);
        axw(watchdog_pkg::ADDR_IRQ_CLEAR, 32'h3);
        axr(watchdog_pkg::ADDR_IRQ_CLEAR);
        chk(rd, 32'h0);
        chk(irq, 1'h0);
        start(4'h8, 8'h05);
        repeat (4)
        begin
            op(4'h8);
            wait_ovf(300 + rnd() % 600);
            chk({dr, pr}, 2'h0);
        end
        op(4'h1);
        wait_ovf(900);
        chk({dr, pr}, 2'h0);
        @(posedge aclk);
        external_reset_pin_n <= 1'h0;
        wait_ovf(1500);
        chk({dr, pr}, 2'h0);
        @(posedge aclk);
        external_reset_pin_n <= 1'h1;
        wait_ovf(1100);
        chk(dr, 1'h1);
        start(4'h9, 8'h05);
        op(4'h4);
        wait_ovf(600);
        chk(dr, 1'h0);
        op(4'h4);
        wait_ovf(600);
        chk(dr, 1'h1);
        for (int j = 0; j < 6; j++)
        begin
            op(j[0] ? 4'h4 : 4'h2);
            wait_ovf(700);
            chk(dr, 1'h0);
        end
        start(4'h8, 8'h05);
        req(3'h4);
        wait_ovf(1500);
        chk({dr, pr, powerdown_flag, timeout_flag}, 4'h2);
        req(3'h1);
        req(3'h2);
        wait_ovf(1500);
        chk({dr, pr}, 2'h0);
        req(3'h1);
        axw(watchdog_pkg::ADDR_CONTROL, 32'h85);
        chk(idle_sysclk_keep, 1'h1);
        req(3'h2);
        wait_ovf(1500);
        chk({dr, pr, timeout_flag, powerdown_flag}, 4'h7);
        start(4'hE, 8'h05);
        req(3'h2);
        wait_ovf(1500);
        chk({dr, pr}, 2'h1);
        tally_and_finish;
    end
endmodule

bind watchdog_timer watchdog_timer_chk u_watchdog_timer_chk (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .cfg(cfg), .ops(ops),
    .power_mode(power_mode), .external_reset_pin_n(external_reset_pin_n),
    .device_reset(device_reset), .pc_sp_reset(pc_sp_reset),
    .timeout_flag(timeout_flag));
